// ==== hdl/slbc_sync_ctrl.sv ====
// sync processing, frequency lock, clamp/blanking and line phase offsets
// How it works
// - line or composite sync is normalised to one polarity whatever its input polarity.
// - normalised line sync feeds vertical integrator, phase comparator and frequency loop.
// - composite sync integration, rate set by reference current, triggers vertical oscillator.
// - normalised vertical sync is ORed with integrator output to trigger vertical.
// - clamp pulse starts on the leading or trailing sync edge, chosen by a bit.
// - clamp width comes from a fixed one-shot, not from sync width.
// - vertical blanking starts at vertical sync and ends after a set count of line oscillator lines.
// - one control bit chooses between two vertical blanking lengths.
// - soft start, search unlock, missing flyback, x-ray or low supply blank continuously.
// - the disable bit removes only unlock blanking; vertical blanking stays.
// - without line sync the oscillator free-runs at its minimum frequency.
// - more than 4 percent mismatch enters search and stops phase corrections at once.
// - search retunes the oscillator with small steady steps, a fixed rate.
// - on coincidence, soft lock until early next vertical period, then normal lock.
// - buffered frequency value is sampled only outside sync and vertical integration.
// - unlock output floats during search and under any protection condition.
// - otherwise unlock output drives vertical blanking only.
// - phase comparator checks sync midpoint against a fixed ramp point, fixed step size.
// - position setting shifts the primary loop phase linearly, same at every frequency.
// - parallelogram and pin unbalance shift the secondary phase; disconnect bit removes them.
// - line rate divided by two modulates secondary phase, amplitude from moire setting.
// - moire polarity flips each vertical period; a bit disables moire entirely.
// - after soft start and lock, unlock output drives again and continuous blanking ends.
// - soft start bit clear or filter low inhibits drive, loops, and forces blanking.
`timescale 1ns/10ps
module slbc_sync_ctrl (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsyncIn,
	input wire logic vsyncIn,
	input wire logic flybackIn,
	input wire logic xrayTrip,
	input wire logic supplyLow,
	input wire logic secondaryFilterLow,
	input wire logic softStartControl,
	input wire logic clampEdgeTrailing,
	input wire logic blankLengthSelect,
	input wire logic unlockBlankDisable,
	input wire logic asymCorrDisconnect,
	input wire logic moireDisable,
	input wire logic [7:0] linePositionSetting,
	input wire logic [7:0] parallelogramSetting,
	input wire logic [7:0] pinUnbalanceSetting,
	input wire logic [7:0] moireAmplitudeSetting,
	input wire logic [7:0] lineReferenceCurrent,
	output logic [1:0] clampBlankOut,
	output logic unlockIndicatorOut,
	output logic unlockIndicatorOe,
	output logic vertTrigger,
	output logic searchMode,
	output logic lockMode,
	output logic driveEnable,
	output logic [11:0] bufferedFreqVoltage,
	output logic signed [10:0] secondaryPhaseOffset,
	output logic signed [9:0] asymCorrectionOut
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [5:0] syn1;
		logic [5:0] syn2;
		logic hPrev;
		logic vPrev;
		logic fPrev;
		logic xrayLatch;
		logic [11:0] softCnt;
		logic [11:0] flyIdle;
		logic [11:0] syncCnt;
		logic syncValid;
		logic [11:0] ramp;
		logic [11:0] oscPeriod;
		logic [11:0] rampAtLead;
		logic phaseUp;
		logic phaseDn;
		slbc_pkg::slbc_fll_t mode;
		logic softArm;
		logic [7:0] softLines;
		logic [15:0] vintAcc;
		logic vBlank;
		logic [9:0] vLines;
		logic [7:0] clampCnt;
		logic lineToggle;
		logic frameToggle;
		logic [11:0] heldFreq;
		logic [1:0] cbOut;
		logic unlockOut;
		logic unlockOe;
		logic vTrigOut;
		logic driveEn;
		logic signed [10:0] secPhase;
		logic signed [9:0] asymOut;
		logic searchOut;
		logic lockOut;
	} slbc_state_t;

	slbc_state_t st_ff;
	slbc_state_t nxt_st;

	slbc_pol_if hPol ();
	slbc_pol_if vPol ();

	// one normaliser per sync input; the same logic serves both
	slbc_sync_polarity u_hpol (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pol(hPol)
	);
	slbc_sync_polarity u_vpol (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pol(vPol)
	);

	// mismatch above 4 percent of the oscillator period
	function automatic logic outOfTol(input logic [11:0] meas, input logic [11:0] osc);
		logic [11:0] d;
		d = (meas > osc) ? meas - osc : osc - meas;
		return (17'(d) * 17'(slbc_pkg::TOL_RATIO)) > 17'(osc);
	endfunction : outOfTol

	// ************************************************************
	// edges and status terms shared by logic and checks
	// ************************************************************
	logic hNorm;
	logic vNorm;
	logic hLead;
	logic hTrail;
	logic vRise;
	logic flyEdge;
	logic noFly;
	logic noSync;
	logic softDone;
	logic prot;
	logic rampWrap;
	logic clampEdge;

	assign hPol.raw = st_ff.syn2[slbc_pkg::SY_H];
	assign vPol.raw = st_ff.syn2[slbc_pkg::SY_V];
	assign hNorm = hPol.norm;
	assign vNorm = vPol.norm;
	assign hLead = hNorm & ~st_ff.hPrev;
	assign hTrail = ~hNorm & st_ff.hPrev;
	assign vRise = vNorm & ~st_ff.vPrev;
	assign flyEdge = st_ff.syn2[slbc_pkg::SY_FLY] & ~st_ff.fPrev;
	assign noFly = st_ff.flyIdle == slbc_pkg::FLYBACK_TIMEOUT;
	assign noSync = st_ff.syncCnt == slbc_pkg::NOSYNC_LIMIT;
	assign softDone = st_ff.softCnt == slbc_pkg::SOFTSTART_CYCLES;
	assign prot = ~softDone | st_ff.xrayLatch | noFly | st_ff.syn2[slbc_pkg::SY_SUPLO];
	assign rampWrap = st_ff.ramp >= st_ff.oscPeriod - 12'h001;
	assign clampEdge = clampEdgeTrailing ? hTrail : hLead;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic softReq;
		logic vTrig;
		logic contBlank;
		logic [16:0] accSum;
		logic [11:0] mid;
		logic [11:0] target;
		logic signed [9:0] asym;
		logic signed [10:0] moire;
		softReq = 1'b0;
		vTrig = 1'b0;
		contBlank = 1'b0;
		accSum = '0;
		mid = '0;
		target = '0;
		asym = '0;
		moire = '0;
		nxt_st = st_ff;
		// pins pass two flops before anything looks at them
		nxt_st.syn1 = {secondaryFilterLow, supplyLow, xrayTrip, flybackIn, vsyncIn, hsyncIn};
		nxt_st.syn2 = st_ff.syn1;
		nxt_st.hPrev = hNorm;
		nxt_st.vPrev = vNorm;
		nxt_st.fPrev = st_ff.syn2[slbc_pkg::SY_FLY];

		// x-ray latch holds until software clears the soft start bit; a trip wins
		nxt_st.xrayLatch = st_ff.syn2[slbc_pkg::SY_XRAY] | (st_ff.xrayLatch & softStartControl);
		softReq = softStartControl & ~st_ff.syn2[slbc_pkg::SY_FILT] & ~st_ff.xrayLatch
			& ~st_ff.syn2[slbc_pkg::SY_SUPLO];
		if (!softReq) begin
			nxt_st.softCnt = '0;
		end else if (!softDone) begin
			nxt_st.softCnt = st_ff.softCnt + 12'h001;
		end
		nxt_st.driveEn = softReq & softDone;
		if (flyEdge) begin
			nxt_st.flyIdle = '0;
		end else if (!noFly) begin
			nxt_st.flyIdle = st_ff.flyIdle + 12'h001;
		end

		// line oscillator ramp; a pending phase correction stretches or skips one count
		if (rampWrap) begin
			nxt_st.ramp = '0;
		end else if (st_ff.phaseUp) begin
			nxt_st.ramp = st_ff.ramp + 12'h002;
		end else if (!st_ff.phaseDn) begin
			nxt_st.ramp = st_ff.ramp + 12'h001;
		end
		nxt_st.phaseUp = 1'b0;
		nxt_st.phaseDn = 1'b0;
		nxt_st.lineToggle = st_ff.lineToggle ^ rampWrap;

		// sync period measurement
		if (hLead) begin
			nxt_st.syncCnt = '0;
			nxt_st.rampAtLead = st_ff.ramp;
			nxt_st.syncValid = 1'b1;
		end else if (!noSync) begin
			nxt_st.syncCnt = st_ff.syncCnt + 12'h001;
		end

		// vertical: composite integrator ORed with separate vertical sync
		accSum = 17'(st_ff.vintAcc) + 17'(lineReferenceCurrent);
		nxt_st.vintAcc = hNorm ? (accSum[16] ? 16'hffff : accSum[15:0]) : 16'h0000;
		vTrig = (hNorm && st_ff.vintAcc < slbc_pkg::VINT_LEVEL && accSum >= 17'(slbc_pkg::VINT_LEVEL))
			|| vRise;
		nxt_st.vTrigOut = vTrig;
		nxt_st.frameToggle = st_ff.frameToggle ^ vTrig;

		// frequency-locked loop
		if (noSync) begin
			nxt_st.mode = slbc_pkg::FLL_SEARCH;
			nxt_st.oscPeriod = slbc_pkg::OSC_PERIOD_MAX;
			nxt_st.syncValid = 1'b0;
		end else if (!softDone) begin
			nxt_st.mode = slbc_pkg::FLL_SEARCH;
		end else begin
			if (hLead && st_ff.syncValid) begin
				if (outOfTol(st_ff.syncCnt, st_ff.oscPeriod)) begin
					nxt_st.mode = slbc_pkg::FLL_SEARCH;
				end else if (st_ff.mode == slbc_pkg::FLL_SEARCH) begin
					nxt_st.mode = slbc_pkg::FLL_SOFT;
					nxt_st.softArm = 1'b0;
					nxt_st.softLines = '0;
				end
			end
			// one period count per line: slow, steady retune
			if (st_ff.mode == slbc_pkg::FLL_SEARCH && rampWrap && st_ff.syncValid) begin
				if (st_ff.syncCnt > st_ff.oscPeriod && st_ff.oscPeriod < slbc_pkg::OSC_PERIOD_MAX) begin
					nxt_st.oscPeriod = st_ff.oscPeriod + 12'h001;
				end else if (st_ff.syncCnt < st_ff.oscPeriod
					&& st_ff.oscPeriod > slbc_pkg::OSC_PERIOD_MIN) begin
					nxt_st.oscPeriod = st_ff.oscPeriod - 12'h001;
				end
			end
			if (st_ff.mode == slbc_pkg::FLL_SOFT && nxt_st.mode == slbc_pkg::FLL_SOFT) begin
				if (vTrig) begin
					nxt_st.softArm = 1'b1;
				end else if (st_ff.softArm && rampWrap) begin
					nxt_st.softLines = st_ff.softLines + 8'h01;
					if (st_ff.softLines == slbc_pkg::SOFTLOCK_LINES) begin
						nxt_st.mode = slbc_pkg::FLL_LOCK;
					end
				end
			end
		end

		// phase comparator: sync midpoint against shifted ramp point
		mid = st_ff.rampAtLead + (st_ff.syncCnt >> 1);
		target = slbc_pkg::PHASE_REF + 12'(linePositionSetting);
		if (hTrail && nxt_st.mode == slbc_pkg::FLL_LOCK) begin
			nxt_st.phaseDn = mid > target;
			nxt_st.phaseUp = mid < target;
		end
		if (nxt_st.mode != slbc_pkg::FLL_LOCK) begin
			nxt_st.phaseUp = 1'b0;
			nxt_st.phaseDn = 1'b0;
		end
		// mode flags kept in flops so the mode pins carry no decode glitches
		nxt_st.searchOut = nxt_st.mode == slbc_pkg::FLL_SEARCH;
		nxt_st.lockOut = nxt_st.mode == slbc_pkg::FLL_LOCK;

		// held frequency value, frozen inside sync and vertical integration
		if (!hNorm && st_ff.vintAcc == 16'h0000) begin
			nxt_st.heldFreq = st_ff.oscPeriod;
		end

		// vertical blanking, counted in lines of the line oscillator
		if (vTrig) begin
			nxt_st.vBlank = 1'b1;
			nxt_st.vLines = '0;
		end else if (st_ff.vBlank && rampWrap) begin
			nxt_st.vLines = st_ff.vLines + 10'h001;
			if (st_ff.vLines + 10'h001 >= (blankLengthSelect ? slbc_pkg::VBLANK_LONG
				: slbc_pkg::VBLANK_SHORT)) begin
				nxt_st.vBlank = 1'b0;
			end
		end

		// clamp one-shot
		if (clampEdge) begin
			nxt_st.clampCnt = slbc_pkg::CLAMP_CYCLES;
		end else if (st_ff.clampCnt != 8'h00) begin
			nxt_st.clampCnt = st_ff.clampCnt - 8'h01;
		end

		// continuous blanking; the disable bit masks only the unlock term
		contBlank = prot || (st_ff.mode == slbc_pkg::FLL_SEARCH && !unlockBlankDisable);
		if (nxt_st.clampCnt != 8'h00) begin
			nxt_st.cbOut = slbc_pkg::CB_CLAMP;
		end else if (nxt_st.vBlank || contBlank) begin
			nxt_st.cbOut = slbc_pkg::CB_VBLANK;
		end else begin
			nxt_st.cbOut = slbc_pkg::CB_NONE;
		end
		nxt_st.unlockOe = !(st_ff.mode == slbc_pkg::FLL_SEARCH || prot);
		nxt_st.unlockOut = nxt_st.unlockOe && (nxt_st.vBlank || contBlank);

		// secondary loop phase: asymmetric terms plus moire at half line rate
		asym = 10'(signed'(parallelogramSetting)) + 10'(signed'(pinUnbalanceSetting));
		nxt_st.asymOut = asym;
		moire = (st_ff.lineToggle ^ st_ff.frameToggle) ? 11'(moireAmplitudeSetting)
			: -11'(moireAmplitudeSetting);
		if (!softDone) begin
			nxt_st.secPhase = '0;
		end else begin
			nxt_st.secPhase = (asymCorrDisconnect ? 11'sh000 : 11'(asym))
				+ (moireDisable ? 11'sh000 : moire);
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.oscPeriod <= slbc_pkg::OSC_PERIOD_MAX;
			st_ff.searchOut <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign clampBlankOut = st_ff.cbOut;
	assign unlockIndicatorOut = st_ff.unlockOut;
	assign unlockIndicatorOe = st_ff.unlockOe;
	assign vertTrigger = st_ff.vTrigOut;
	assign searchMode = st_ff.searchOut;
	assign lockMode = st_ff.lockOut;
	assign driveEnable = st_ff.driveEn;
	assign bufferedFreqVoltage = st_ff.heldFreq;
	assign secondaryPhaseOffset = st_ff.secPhase;
	assign asymCorrectionOut = st_ff.asymOut;

	// ************************************************************
	// checks
	// ************************************************************
	chk_clamp_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		clampEdge |=> clampBlankOut == slbc_pkg::CB_CLAMP)
		else $error("clamp did not start on the selected sync edge");
	chk_clamp_width: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(clampBlankOut == slbc_pkg::CB_CLAMP) && !clampEdge
		|-> (clampBlankOut == slbc_pkg::CB_CLAMP)[*5] ##1 clampBlankOut != slbc_pkg::CB_CLAMP)
		else $error("clamp width is not the one-shot width");
	chk_vsync_or: assert property (@(posedge core_clk) disable iff (!rst_n)
		vRise |=> vertTrigger)
		else $error("vertical sync edge gave no vertical trigger");
	chk_search_phase: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_ff.mode == slbc_pkg::FLL_SEARCH |-> !st_ff.phaseUp && !st_ff.phaseDn)
		else $error("phase correction active in search");
	chk_unlock_float: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_ff.mode == slbc_pkg::FLL_SEARCH || prot) |=> !unlockIndicatorOe)
		else $error("unlock output driven during search or protection");
	chk_unlock_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(st_ff.mode == slbc_pkg::FLL_SEARCH || prot) |=> unlockIndicatorOe
		&& unlockIndicatorOut == st_ff.vBlank)
		else $error("unlock output not driving vertical blanking");
	chk_prot_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_ff.syn2[slbc_pkg::SY_SUPLO] || noFly |=> clampBlankOut != slbc_pkg::CB_NONE)
		else $error("protection did not blank");
	chk_drive_inhibit: assert property (@(posedge core_clk) disable iff (!rst_n)
		!softStartControl |=> !driveEnable ##1 secondaryPhaseOffset == 11'sh000)
		else $error("drive not inhibited without soft start bit");
	chk_free_run: assert property (@(posedge core_clk) disable iff (!rst_n)
		noSync |=> st_ff.oscPeriod == slbc_pkg::OSC_PERIOD_MAX && searchMode)
		else $error("oscillator not free-running at minimum frequency");
	chk_moire_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		moireDisable && asymCorrDisconnect |=> secondaryPhaseOffset == 11'sh000)
		else $error("secondary phase modulated while disconnected");
	cov_lock: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(lockMode));
	cov_soft: cover property (@(posedge core_clk) disable iff (!rst_n)
		st_ff.mode == slbc_pkg::FLL_SOFT && vertTrigger);
	cov_clamp: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(clampBlankOut == 2'h2));
	cov_unlock: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(unlockIndicatorOe));

endmodule : slbc_sync_ctrl

// ==== hdl/slbc_pkg.sv ====
// shared constants and types of the sync, lock and blanking controller
package slbc_pkg;

	// ************************************************************
	// line oscillator and frequency-locked loop
	// ************************************************************
	localparam logic [11:0] OSC_PERIOD_MAX = 12'h2bc; // free-run period, lowest line rate
	localparam logic [11:0] OSC_PERIOD_MIN = 12'h064; // highest line rate the ramp allows
	localparam logic [11:0] NOSYNC_LIMIT = 12'hbb8; // cycles without a sync lead edge
	localparam logic [4:0] TOL_RATIO = 5'h19; // 25 parts, i.e. a 4 percent window
	localparam logic [7:0] SOFTLOCK_LINES = 8'h40; // lines of soft lock after vertical sync
	localparam logic [11:0] PHASE_REF = 12'h020; // fixed point on the line ramp

	// ************************************************************
	// vertical, clamp, protection timing
	// ************************************************************
	localparam logic [15:0] VINT_LEVEL = 16'h0fa0; // composite integrator trip level
	localparam logic [9:0] VBLANK_SHORT = 10'h014; // blanking lines, short setting
	localparam logic [9:0] VBLANK_LONG = 10'h028; // blanking lines, long setting
	localparam logic [7:0] CLAMP_CYCLES = 8'h05; // clamp one-shot width
	localparam logic [11:0] FLYBACK_TIMEOUT = 12'h5dc; // cycles without flyback
	localparam logic [11:0] SOFTSTART_CYCLES = 12'hfa0; // soft-start ramp length

	// ************************************************************
	// polarity integrator
	// ************************************************************
	localparam logic [7:0] POL_HIGH = 8'hc0; // above: input idles high
	localparam logic [7:0] POL_LOW = 8'h40; // below: input idles low

	// ************************************************************
	// sandcastle levels and synchroniser bit positions
	// ************************************************************
	localparam logic [1:0] CB_NONE = 2'h0;
	localparam logic [1:0] CB_VBLANK = 2'h1;
	localparam logic [1:0] CB_CLAMP = 2'h2;
	localparam int SY_H = 0;
	localparam int SY_V = 1;
	localparam int SY_FLY = 2;
	localparam int SY_XRAY = 3;
	localparam int SY_SUPLO = 4;
	localparam int SY_FILT = 5;

	typedef enum logic [1:0] {FLL_SEARCH, FLL_SOFT, FLL_LOCK} slbc_fll_t;

endpackage : slbc_pkg

// ==== hdl/slbc_pol_if.sv ====
// carrier between the core and a sync polarity normaliser
`timescale 1ns/10ps
interface slbc_pol_if;
	logic raw;
	logic norm;
	logic activeLow;
	modport core (output raw, input norm, input activeLow);
	modport conv (input raw, output norm, output activeLow);
endinterface : slbc_pol_if

// ==== hdl/slbc_sync_polarity.sv ====
// sync polarity detector and normaliser
`timescale 1ns/10ps
module slbc_sync_polarity (
	input wire logic core_clk,
	input wire logic rst_n,
	slbc_pol_if.conv pol
);

	typedef struct packed {
		logic [7:0] integ;
		logic activeLow;
		logic norm;
	} slbc_pol_state_t;

	slbc_pol_state_t st_ff;
	slbc_pol_state_t nxt_st;

	// duty integrator: sync pulses are short, so the idle level dominates
	always_comb begin
		nxt_st = st_ff;
		if (pol.raw && st_ff.integ != 8'hff) begin
			nxt_st.integ = st_ff.integ + 8'h01;
		end else if (!pol.raw && st_ff.integ != 8'h00) begin
			nxt_st.integ = st_ff.integ - 8'h01;
		end
		// hysteresis keeps the polarity from chattering on a noisy line
		if (st_ff.integ > slbc_pkg::POL_HIGH) begin
			nxt_st.activeLow = 1'b1;
		end else if (st_ff.integ < slbc_pkg::POL_LOW) begin
			nxt_st.activeLow = 1'b0;
		end
		nxt_st.norm = pol.raw ^ st_ff.activeLow;
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pol.norm = st_ff.norm;
	assign pol.activeLow = st_ff.activeLow;

endmodule : slbc_sync_polarity

// ==== dv/slbc_sync_source.sv ====
// graphics sync source with flyback return, the far side of the controller
`timescale 1ns/10ps
module slbc_sync_source (
	input wire logic core_clk,
	input wire logic [11:0] period,
	input wire logic [11:0] width,
	input wire logic activeLow,
	input wire logic flyOn,
	output logic hsync,
	output logic flyback
);
	logic [11:0] lineCount_ff = 12'h000;
	initial hsync = 1'b0;
	initial flyback = 1'b0;

	// ************************************************************
	// line timing
	// ************************************************************
	// a zero period means no sync at all: the pin rests at its idle level
	always @(posedge core_clk) begin
		lineCount_ff <= (lineCount_ff + 12'h001 >= period) ? 12'h000 : lineCount_ff + 12'h001;
		hsync <= #1 ((period != 12'h000) && (lineCount_ff < width)) ^ activeLow;
		// flyback follows sync by a fixed deflection delay
		flyback <= #1 flyOn && (lineCount_ff >= width + 12'h00a) &&
			(lineCount_ff < width + 12'h014);
	end
endmodule : slbc_sync_source

// ==== dv/testbench.sv ====
// self-checking bench of the sync, lock and blanking controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin tick; k++; end \
	if (!(c)) begin fails++; end_of_test; end end
module testbench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic vsyncIn = 1'b0;
	logic [3:0] prot = 4'h0; // x-ray, filter low, flyback missing, supply low
	logic softStartControl = 1'b0;
	logic clampEdgeTrailing = 1'b0;
	logic blankLengthSelect = 1'b0;
	logic unlockBlankDisable = 1'b0;
	logic asymCorrDisconnect = 1'b0;
	logic moireDisable = 1'b1;
	logic [11:0] period = 12'h2b2; // inside the lock window of the free-run rate
	logic [11:0] width = 12'h014;
	logic activeLow = 1'b0;
	logic [7:0] refCur = 8'h10; // integrator step per active sync cycle
	logic hsyncIn, flybackIn, unlockIndicatorOut, unlockIndicatorOe, vertTrigger;
	logic searchMode, lockMode, driveEnable;
	logic [1:0] clampBlankOut;
	logic [11:0] bufferedFreqVoltage;
	logic signed [10:0] secondaryPhaseOffset;
	logic signed [9:0] asymCorrectionOut;
	int fails = 0;
	int checkCount = 0;
	int z, pos;

	// ************************************************************
	// clock, source and design
	// ************************************************************
	always #50 core_clk = ~core_clk;
	slbc_sync_source i_src (.core_clk, .period, .width, .activeLow, .flyOn(!prot[1]),
		.hsync(hsyncIn), .flyback(flybackIn));
	slbc_sync_ctrl i_dut (.core_clk, .rst_n, .hsyncIn, .vsyncIn, .flybackIn,
		.xrayTrip(prot[3]), .supplyLow(prot[0]), .secondaryFilterLow(prot[2]),
		.softStartControl, .clampEdgeTrailing, .blankLengthSelect, .unlockBlankDisable,
		.asymCorrDisconnect, .moireDisable, .linePositionSetting(8'h10),
		.parallelogramSetting(8'hf0), .pinUnbalanceSetting(8'h05),
		.moireAmplitudeSetting(8'h12), .lineReferenceCurrent(refCur), .clampBlankOut,
		.unlockIndicatorOut, .unlockIndicatorOe, .vertTrigger, .searchMode, .lockMode,
		.driveEnable, .bufferedFreqVoltage, .secondaryPhaseOffset, .asymCorrectionOut);

	// ************************************************************
	// access tasks
	// ************************************************************
	// drive and sample 1 ns after the edge, once flops have settled
	task tick;
		@(posedge core_clk);
		#1;
	endtask : tick

	task end_of_test;
		if (fails == 0 && checkCount > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test

	// counts cycles without any sandcastle level
	task automatic zeros(input int n, output int zc);
		zc = 0;
		repeat (n) begin tick; zc += (clampBlankOut === 2'h0); end
	endtask : zeros

	// vertical pulse, then length of blanking on the unlock pin in cycles
	task automatic vblank(input logic sel, input int lines);
		int n;
		n = 0;
		blankLengthSelect = sel;
		vsyncIn = 1'b1;
		`WAITC(vertTrigger === 1'b1, 300)
		`CHK("vertTrig", 1'b1, vertTrigger)
		repeat (2) tick;
		while (unlockIndicatorOut === 1'b1 && n < 40000) begin
			tick;
			n++;
			if (n == 100) vsyncIn = 1'b0;
		end
		`CHK("vblankLen", 1'b1, n > (lines - 1) * 690 && n < (lines + 1) * 700)
	endtask : vblank

	// delay from the selected active sync edge to the clamp, and clamp width
	task automatic clampChk(input logic trail);
		int d;
		int w;
		d = 0;
		w = 0;
		clampEdgeTrailing = trail;
		`WAITC((hsyncIn ^ activeLow) === trail, 1400)
		`WAITC((hsyncIn ^ activeLow) !== trail, 1400)
		while (clampBlankOut !== 2'h2 && d < 12) begin tick; d++; end
		while (clampBlankOut === 2'h2 && w < 20) begin tick; w++; end
		`CHK("clampDelay", 1'b1, d >= 2 && d <= 7)
		`CHK("clampWidth", 5, w)
	endtask : clampChk

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (3) tick;
		`CHK("blankReset", 2'h0, clampBlankOut)
		rst_n = 1'b1;
		repeat (2) tick;
		`CHK("softBlank", 2'h1, clampBlankOut)
		softStartControl = 1'b1;
		repeat (3990) tick;
		`CHK("driveEarly", 1'b0, driveEnable)
		`WAITC(driveEnable === 1'b1, 30)
		`WAITC(searchMode === 1'b0, 3000)
		repeat (2) tick;
		`CHK("softOe", 1'b1, unlockIndicatorOe)
		// soft lock: both blanking lengths measured while waiting for lock
		vblank(1'b0, 20);
		vblank(1'b1, 40);
		`WAITC(lockMode === 1'b1, 50000)
		`CHK("lockSearch", 1'b0, searchMode)
		clampChk(1'b0);
		clampChk(1'b1);
		// inverted and wider sync must give the same clamp
		activeLow = 1'b1;
		width = 12'h028;
		repeat (3000) tick;
		clampChk(1'b0);
		for (int a = 0; a < 2; a++) begin
			asymCorrDisconnect = a[0];
			repeat (4) tick;
			`CHK("asymOut", 10'h3f5, asymCorrectionOut)
			`CHK("phase2", a ? 11'h000 : 11'h7f5, secondaryPhaseOffset)
		end
		moireDisable = 1'b0;
		pos = 0;
		for (int s = 0; s < 8; s++) begin
			repeat (345) tick;
			`CHK("moire", 1'b1, secondaryPhaseOffset === 11'h012 || secondaryPhaseOffset === 11'h7ee)
			pos += (secondaryPhaseOffset === 11'h012);
		end
		`CHK("moireFlip", 1'b1, pos > 0 && pos < 8)
		moireDisable = 1'b1;
		period = 12'h258;
		`WAITC(searchMode === 1'b1, 1500)
		`CHK("searchLock", 1'b0, lockMode)
		repeat (2) tick;
		`CHK("searchOe", 1'b0, unlockIndicatorOe)
		zeros(700, z);
		`CHK("searchBlank", 0, z)
		unlockBlankDisable = 1'b1;
		zeros(700, z);
		`CHK("blankDis", 1'b1, z > 0)
		`CHK("retune", 1'b1, bufferedFreqVoltage < 12'h2bc && bufferedFreqVoltage >= 12'h258)
		period = 12'h000;
		repeat (3900) tick;
		`CHK("freeRun", 12'h2bc, bufferedFreqVoltage)
		period = 12'h2b2;
		// each protection source alone; x-ray last as it latches
		for (int i = 0; i < 4; i++) begin
			prot = 4'h1 << i;
			repeat (1600) tick;
			zeros(700, z);
			`CHK("protBlank", 0, z)
			`CHK("protOe", 1'b0, unlockIndicatorOe)
			if (i >= 2) `CHK("protDrive", 1'b0, driveEnable)
			if (i < 3) prot = 4'h0;
		end
		// broad sync pulses must trip the composite integrator; done last since the
		// blanking it starts would hide the checks above; a larger step trips it
		// before the polarity detector starts to follow the long pulse
		refCur = 8'h20;
		width = 12'h12c;
		`WAITC(vertTrigger === 1'b1, 1500)
		`CHK("intTrig", 1'b1, vertTrigger)
		end_of_test;
	end
endmodule : testbench
